// ### design/pbs_pkg.sv
// Package for the pipelined burst memory: widths, field positions and codes.
// Assumes the memory and its helpers all refer to these names by scope.
package pbs_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 18;
  localparam int DEPTH = 65536;
  localparam int BYTE_W = 9;
  localparam int LOW_LSB = 0;
  localparam int HIGH_LSB = 9;
  localparam int BURST_W = 2;
  localparam logic [1:0] BURST_ZERO = 2'h0;
  localparam logic [17:0] DATA_ZERO = 18'h00000;
  localparam logic [15:0] ADDR_ZERO = 16'h0000;
  // Operation decoded from the sampled control inputs.
  typedef enum logic [2:0] {
    PBS_OP_IDLE = 3'b000,
    PBS_OP_READ_LOAD = 3'b001,
    PBS_OP_WRITE_LOAD = 3'b010,
    PBS_OP_READ_CONT = 3'b011,
    PBS_OP_WRITE_CONT = 3'b100,
    PBS_OP_DESELECT = 3'b101
  } pbs_op_t;
endpackage

// ### design/pbs_burst_if.sv
// Interface carrying the burst address between the counter and the memory core.
// Assumes a single clock domain shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface pbs_burst_if;
  logic load;
  logic step;
  logic [15:0] base;
  logic [15:0] addr;
  modport ctrl (output load, output step, output base, input addr);
  modport counter (input load, input step, input base, output addr);
endinterface
`default_nettype wire

// ### design/pbs_burst_counter.sv
// Two-bit interleaved burst address generator.
// Assumes load and step are never both needed in one cycle; load wins.
`timescale 1ns/1ps
`default_nettype none
module pbs_burst_counter
(
  input wire logic clk,
  input wire logic rst_n,
  pbs_burst_if.counter bus
);
  logic [15:0] base;
  logic [1:0] count;
  logic [1:0] next_count;

  // Count wraps after four accesses, returning to the loaded base.
  assign next_count = bus.load ? pbs_pkg::BURST_ZERO : bus.step ? count + 2'h1 : count;
  // Interleaved order: high bits fixed, low bits XOR the counter. The address
  // is the one for this very cycle, so a load shows the new base at once and
  // a step shows the advanced count before the access is carried out.
  assign bus.addr = bus.load ? bus.base : {base[15:2], base[1:0] ^ next_count};

  // Base and counter registers.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      base <= pbs_pkg::ADDR_ZERO;
      count <= pbs_pkg::BURST_ZERO;
    end
    else
    begin
      if (bus.load)
        base <= bus.base;
      count <= next_count;
    end
  end

  AST_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
    (!bus.load && bus.step && count == 2'h3) |=> (count == 2'h0))
    else $error("burst counter did not wrap");
endmodule
`default_nettype wire

// ### design/pbs_sram.sv
// Synchronous 64K x 18 burst memory with registered outputs and pass-through.
// Assumes the bus master honours setup/hold and drives output enable high
// before presenting write data after a read.
// Overview of operation
// - Register address, data and controls each edge
// - Array of 65536 words by 18 bits
// - Read data leaves through output register
// - Output enable acts combinationally on drivers
// - Processor strobe loads address and reads
// - Controller strobe loads; writes if enable low
// - Chip enable matters only on loads
// - Processor strobe ignored while chip disabled
// - Low advance steps address before access
// - Upper fourteen address bits stay fixed
// - Two-bit counter wraps to base address
// - Write is self-timed from clock edge
// - Low enable bits 0-8, high bits 9-17
// - Read after write forwards written data
// - Forwarded data has normal read latency
// - Forwarding works without chip enable
// - Output enable still gates forwarded data
// - High advance repeats current address
// - Deselect: no access, outputs high impedance unless it follows a write
`timescale 1ns/1ps
`default_nettype none
module pbs_sram
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] addr_in,
  input wire logic chip_enable_n,
  input wire logic processor_load_strobe,
  input wire logic controller_load_strobe,
  input wire logic burst_step_n,
  input wire logic low_byte_write_n,
  input wire logic high_byte_write_n,
  input wire logic output_enable_n,
  input wire logic [17:0] shared_io_bus_in,
  output logic [17:0] shared_io_bus_out,
  output logic [17:0] shared_io_bus_oe
);
  logic [17:0] mem [0:pbs_pkg::DEPTH-1];
  pbs_burst_if burst ();

  // Input registers, all but output enable.
  logic [15:0] addr_q;
  logic [17:0] din_q;
  logic ce_n_q;
  logic proc_q;
  logic ctrl_q;
  logic step_n_q;
  logic lw_n_q;
  logic hw_n_q;
  logic active;

  // Input capture on every edge, no inversion.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_q <= pbs_pkg::ADDR_ZERO;
      din_q <= pbs_pkg::DATA_ZERO;
      ce_n_q <= 1'b1;
      proc_q <= 1'b1;
      ctrl_q <= 1'b1;
      step_n_q <= 1'b1;
      lw_n_q <= 1'b1;
      hw_n_q <= 1'b1;
    end
    else
    begin
      addr_q <= addr_in;
      din_q <= shared_io_bus_in;
      ce_n_q <= chip_enable_n;
      proc_q <= processor_load_strobe;
      ctrl_q <= controller_load_strobe;
      step_n_q <= burst_step_n;
      lw_n_q <= low_byte_write_n;
      hw_n_q <= high_byte_write_n;
    end
  end

  // Decode of the registered controls into one operation.
  function automatic pbs_pkg::pbs_op_t pbs_decode(input logic ce_n, input logic proc,
                                                  input logic ctrl, input logic wr_n,
                                                  input logic act);
    pbs_pkg::pbs_op_t op;
    op = pbs_pkg::PBS_OP_IDLE;
    if (!proc && !ce_n)
      op = pbs_pkg::PBS_OP_READ_LOAD;
    else if (!ctrl && ce_n)
      op = pbs_pkg::PBS_OP_DESELECT;
    else if (!ctrl)
      op = wr_n ? pbs_pkg::PBS_OP_READ_LOAD : pbs_pkg::PBS_OP_WRITE_LOAD;
    else if (act)
      op = wr_n ? pbs_pkg::PBS_OP_READ_CONT : pbs_pkg::PBS_OP_WRITE_CONT;
    return op;
  endfunction

  pbs_pkg::pbs_op_t op;
  logic write_any_n;
  logic is_load;
  logic is_write;
  logic is_read;
  logic [15:0] acc_addr;
  logic [17:0] wmask;

  assign write_any_n = lw_n_q & hw_n_q;
  // A blocked processor strobe on a disabled chip falls through to the deselect and
  // continuation rows; that matches the table, where chip enable is ignored.
  assign op = pbs_decode(ce_n_q, proc_q, ctrl_q, write_any_n, active);
  assign is_load = (op == pbs_pkg::PBS_OP_READ_LOAD) || (op == pbs_pkg::PBS_OP_WRITE_LOAD);
  assign is_write = (op == pbs_pkg::PBS_OP_WRITE_LOAD) || (op == pbs_pkg::PBS_OP_WRITE_CONT);
  assign is_read = (op == pbs_pkg::PBS_OP_READ_LOAD) || (op == pbs_pkg::PBS_OP_READ_CONT);

  // Counter steps only on continuation cycles with advance low.
  assign burst.load = is_load;
  assign burst.base = addr_q;
  assign burst.step = !is_load && (op != pbs_pkg::PBS_OP_DESELECT) && active && !step_n_q;

  pbs_burst_counter u_counter
  (
    .clk(clk),
    .rst_n(rst_n),
    .bus(burst.counter)
  );

  // The counter already shows the loaded, stepped or held address for this
  // cycle, so the core needs no second copy of the burst arithmetic.
  assign acc_addr = burst.addr;

  // Byte masks for the two write enables.
  genvar g;
  generate
    for (g = 0; g < pbs_pkg::DATA_W; g = g + 1)
    begin : g_mask
      assign wmask[g] = (g < pbs_pkg::HIGH_LSB) ? !lw_n_q : !hw_n_q;
    end
  endgenerate

  // Burst is live from a load until deselect.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      active <= 1'b0;
    else if (is_load)
      active <= 1'b1;
    else if (op == pbs_pkg::PBS_OP_DESELECT)
      active <= 1'b0;
  end

  // Self-timed write: committed at the edge after sampling, no pulse needed.
  always_ff @(posedge clk)
  begin
    if (is_write)
      mem[acc_addr] <= (mem[acc_addr] & ~wmask) | (din_q & wmask);
  end

  // Previous write remembered for pass-through.
  logic prev_wr;
  logic [15:0] prev_addr;
  logic [17:0] prev_data;
  logic [17:0] prev_mask;
  logic fwd;
  logic [17:0] rd_word;
  logic [17:0] next_q;
  logic [17:0] next_oe;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_wr <= 1'b0;
      prev_addr <= pbs_pkg::ADDR_ZERO;
      prev_data <= pbs_pkg::DATA_ZERO;
      prev_mask <= pbs_pkg::DATA_ZERO;
    end
    else
    begin
      prev_wr <= is_write;
      prev_addr <= acc_addr;
      prev_data <= din_q;
      prev_mask <= wmask;
    end
  end

  // Read after write returns the written bytes; chip enable is not needed.
  assign fwd = prev_wr && !is_write;
  assign rd_word = mem[acc_addr];
  always_comb
  begin
    next_q = rd_word;
    next_oe = {pbs_pkg::DATA_W{is_read}};
    if (fwd)
    begin
      next_q = prev_data;
      next_oe = prev_mask;
    end
  end

  // Output register: read data appears one edge after the access.
  logic [17:0] q_reg;
  logic [17:0] drv_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q_reg <= pbs_pkg::DATA_ZERO;
      drv_q <= pbs_pkg::DATA_ZERO;
    end
    else
    begin
      q_reg <= next_q;
      drv_q <= next_oe;
    end
  end

  // Output enable is not sampled; it gates the drivers directly.
  assign shared_io_bus_out = q_reg;
  assign shared_io_bus_oe = output_enable_n ? pbs_pkg::DATA_ZERO : drv_q;

  AST_OE_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    output_enable_n |-> (shared_io_bus_oe == 18'h00000))
    else $error("drivers on with output enable high");
  AST_PIPE: assert property (@(posedge clk) disable iff (!rst_n)
    (is_read && !fwd) |=> (q_reg == $past(rd_word)))
    else $error("read data not registered");
  AST_PROC_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
    (!proc_q && !ce_n_q) |-> (op == pbs_pkg::PBS_OP_READ_LOAD && acc_addr == addr_q))
    else $error("processor strobe did not load a read");
  AST_CTRL_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    (proc_q && !ctrl_q && !ce_n_q && !write_any_n) |-> is_write)
    else $error("controller strobe write lost");
  AST_BLOCKED: assert property (@(posedge clk) disable iff (!rst_n)
    (!proc_q && ce_n_q) |-> !is_load)
    else $error("processor strobe honoured while disabled");
  AST_DESEL: assert property (@(posedge clk) disable iff (!rst_n)
    (op == pbs_pkg::PBS_OP_DESELECT) |=> (drv_q == 18'h00000 || $past(fwd)))
    else $error("deselect drove outputs");
  AST_SUSPEND: assert property (@(posedge clk) disable iff (!rst_n)
    (!is_load && step_n_q && active && op != pbs_pkg::PBS_OP_DESELECT)
      |-> (acc_addr == $past(acc_addr)))
    else $error("suspend changed address");
  AST_FWD: assert property (@(posedge clk) disable iff (!rst_n)
    (prev_wr && !is_write) |=> (q_reg == $past(prev_data)))
    else $error("pass-through data wrong");
  AST_HIGH_BITS: assert property (@(posedge clk) disable iff (!rst_n)
    (burst.step) |-> (acc_addr[15:2] == $past(acc_addr[15:2])))
    else $error("burst changed high address bits");

  // Named steps of a burst, so the order checks read like the burst table.
  sequence s_burst_start;
    is_load;
  endsequence

  sequence s_one_step;
    s_burst_start ##1 burst.step;
  endsequence

  sequence s_two_steps;
    s_burst_start ##1 burst.step [*2];
  endsequence

  sequence s_three_steps;
    s_burst_start ##1 burst.step [*3];
  endsequence

  sequence s_four_steps;
    s_burst_start ##1 burst.step [*4];
  endsequence

  // A write, one cycle of anything but a write, then a read of the same word.
  // The gap keeps pass-through out of the way, so the array itself is seen.
  sequence s_write_then_read;
    is_write ##1 !is_write ##1 (is_read && acc_addr == $past(acc_addr, 2));
  endsequence

  // Interleaved order, counted from the loaded base one step at a time.
  AST_FIRST_STEP: assert property (@(posedge clk) disable iff (!rst_n)
    s_one_step |-> (acc_addr[1:0] == ($past(acc_addr[1:0]) ^ 2'h1)))
    else $error("first burst step did not flip bit zero");

  AST_SECOND_STEP: assert property (@(posedge clk) disable iff (!rst_n)
    s_two_steps |-> (acc_addr[1:0] == ($past(acc_addr[1:0], 2) ^ 2'h2)))
    else $error("second burst step did not flip bit one");

  AST_THIRD_STEP: assert property (@(posedge clk) disable iff (!rst_n)
    s_three_steps |-> (acc_addr[1:0] == ($past(acc_addr[1:0], 3) ^ 2'h3)))
    else $error("third burst step did not flip both low bits");

  // After four accesses the burst must come back to where it started.
  AST_BURST_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
    s_four_steps |-> (acc_addr == $past(acc_addr, 4)))
    else $error("burst did not return to its base");

  // Written bytes must be found in the array by a later ordinary read.
  AST_WRITE_LANDS: assert property (@(posedge clk) disable iff (!rst_n)
    s_write_then_read |=> ((q_reg & $past(wmask, 3)) == ($past(din_q, 3) & $past(wmask, 3))))
    else $error("written bytes not read back");

  AST_STEP_GATED: assert property (@(posedge clk) disable iff (!rst_n)
    burst.step |-> (active && !step_n_q))
    else $error("burst stepped without advance");

  // Once a burst is live, chip enable must not stop or restart it.
  AST_CE_IGNORED: assert property (@(posedge clk) disable iff (!rst_n)
    (active && proc_q && ctrl_q) |-> (!is_load && (is_read || is_write)))
    else $error("chip enable disturbed a running burst");

  AST_DESEL_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
    (op == pbs_pkg::PBS_OP_DESELECT) |-> (!is_write && !burst.step))
    else $error("deselect performed an access");

  AST_FWD_MASK: assert property (@(posedge clk) disable iff (!rst_n)
    (prev_wr && !is_write) |=> (drv_q == $past(prev_mask)))
    else $error("pass-through drove the wrong bytes");

  AST_BYTE_LANES: assert property (@(posedge clk) disable iff (!rst_n)
    is_write |-> (wmask == {{9{!hw_n_q}}, {9{!lw_n_q}}}))
    else $error("byte lanes do not follow the write enables");

  // With output enable low the drivers follow the registered mask exactly.
  AST_OE_LIVE: assert property (@(posedge clk) disable iff (!rst_n)
    !output_enable_n |-> (shared_io_bus_oe == drv_q))
    else $error("drivers do not follow the registered mask");

  AST_READ_DRIVES: assert property (@(posedge clk) disable iff (!rst_n)
    (is_read && !fwd) |=> (drv_q == 18'h3FFFF))
    else $error("read did not enable all drivers");

  AST_PROC_NO_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    (!proc_q && !ce_n_q) |-> !is_write)
    else $error("processor strobe allowed a write");

  AST_CTRL_READ: assert property (@(posedge clk) disable iff (!rst_n)
    (proc_q && !ctrl_q && !ce_n_q && write_any_n) |-> (is_read && is_load))
    else $error("controller strobe read lost");
endmodule
`default_nettype wire

// ### sim/pbs_master.sv
// Bus master model: drives the memory's sampled inputs one cycle at a time.
// Assumes the bench calls cyc from one process and the clock runs freely.
`timescale 1ns/1ps
`default_nettype none
module pbs_master
(
  input wire logic clk,
  input wire logic [17:0] q,
  input wire logic [17:0] q_oe,
  output logic [15:0] a,
  output logic ce_n,
  output logic ps_n,
  output logic cs_n,
  output logic adv_n,
  output logic lw_n,
  output logic hw_n,
  output logic oe_n,
  output logic [17:0] bus
);
  logic [17:0] drv;
  // The wire carries the memory where it drives, else the master's data.
  assign bus = (q_oe & q) | (~q_oe & drv);
  // Idle levels at time zero, no access requested.
  initial
  begin
    {ps_n, cs_n, ce_n, adv_n, lw_n, hw_n, oe_n} = 7'h7F;
    a = 16'h0000;
    drv = 18'h00000;
  end
  // One bus cycle, launched just after a rising edge.
  task automatic cyc(input logic [3:0] c, input logic [1:0] w, input logic [15:0] ad,
    input logic [17:0] d, input logic o);
    @(posedge clk);
    {ps_n, cs_n, ce_n, adv_n} <= c;
    {hw_n, lw_n} <= w;
    a <= ad;
    // Released data flips so a stale value never looks like a valid hold.
    drv <= (c[3] && w != 2'b11) ? d : ~drv;
    oe_n <= (c[3] && w != 2'b11) ? 1'b1 : o;
  endtask
endmodule
`default_nettype wire

// ### sim/pbs_sram_tb_top.sv
// Bench for the burst memory: scenarios drive the master model, a monitor
// checks outputs. Assumes data shows two edges after the cycle asking for it.
`timescale 1ns/1ps
`default_nettype none
module pbs_sram_tb_top;
  localparam logic [3:0] P_RD = 4'b0101;
  localparam logic [3:0] C_LD = 4'b1001;
  localparam logic [3:0] STEP = 4'b1110;
  localparam logic [3:0] HOLD = 4'b1111;
  localparam logic [3:0] DESEL = 4'b1011;
  localparam logic [3:0] PS_OFF = 4'b0111;
  localparam logic [17:0] F = 18'h3FFFF;
  logic clk;
  logic rst_n;
  logic [15:0] addr;
  logic ce_n, ps_n, cs_n, adv_n, lw_n, hw_n, oen;
  logic [17:0] bus, q, oe, m;
  logic ev, e1v, e2v;
  logic [17:0] em, ed, e1m, e1d, e2m, e2d;
  int n_mismatch = 0;
  int tests_run = 0;
  pbs_sram pbs_sram_i (.clk(clk), .rst_n(rst_n), .addr_in(addr), .chip_enable_n(ce_n),
    .processor_load_strobe(ps_n), .controller_load_strobe(cs_n), .burst_step_n(adv_n),
    .low_byte_write_n(lw_n), .high_byte_write_n(hw_n), .output_enable_n(oen),
    .shared_io_bus_in(bus), .shared_io_bus_out(q), .shared_io_bus_oe(oe));
  pbs_master pbs_master_i (.clk(clk), .q(q), .q_oe(oe), .a(addr), .ce_n(ce_n), .ps_n(ps_n),
    .cs_n(cs_n), .adv_n(adv_n), .lw_n(lw_n), .hw_n(hw_n), .oe_n(oen), .bus(bus));
  // Free-running 25 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Expectations ride two edges behind their request, matching the pipeline.
  always @(posedge clk)
  begin
    {e1v, e1m, e1d} <= {ev, em, ed};
    {e2v, e2m, e2d} <= {e1v, e1m, e1d};
  end
  // Output enable is applied live, since it must act without the clock.
  always @(negedge clk)
    if (e2v === 1'b1)
    begin
      tests_run++;
      m = e2m & {18{~oen}};
      if (oe !== m || (q & m) !== (e2d & m))
      begin
        n_mismatch++;
        $display("BAD %0t: oe %h data %h, want %h %h", $time, oe, q, m, e2d);
      end
    end
  task automatic op(input logic [3:0] c, input logic [1:0] w, input logic [15:0] a,
    input logic [17:0] d, input logic o, input logic v, input logic [17:0] mk,
    input logic [17:0] x);
    pbs_master_i.cyc(c, w, a, d, o);
    ev <= v;
    em <= mk;
    ed <= x;
  endtask
  task automatic s_forward;
    op(C_LD, 2'b00, 16'h0020, 18'h2AAAA, 1'b0, 1'b0, F, 18'h0);
    op(C_LD, 2'b00, 16'h0010, 18'h15555, 1'b0, 1'b0, F, 18'h0);
    op(P_RD, 2'b11, 16'h0020, 18'h0, 1'b0, 1'b1, F, 18'h15555);
    op(HOLD, 2'b11, 16'h0, 18'h0, 1'b0, 1'b0, F, 18'h0);
    op(P_RD, 2'b00, 16'h0010, 18'h0, 1'b0, 1'b1, F, 18'h15555);
    op(P_RD, 2'b11, 16'h0020, 18'h0, 1'b0, 1'b1, F, 18'h2AAAA);
    op(HOLD, 2'b11, 16'h0, 18'h0, 1'b0, 1'b0, F, 18'h0);
    op(HOLD, 2'b11, 16'h0, 18'h0, 1'b0, 1'b0, F, 18'h0);
  endtask
  task automatic s_bytes;
    op(C_LD, 2'b00, 16'h0030, F, 1'b0, 1'b0, F, 18'h0);
    repeat (2) op(HOLD, 2'b11, 16'h0, 18'h0, 1'b0, 1'b0, F, 18'h0);
    op(C_LD, 2'b01, 16'h0030, 18'h0, 1'b0, 1'b0, F, 18'h0);
    op(HOLD, 2'b11, 16'h0, 18'h0, 1'b0, 1'b1, 18'h3FE00, 18'h0);
    repeat (2) op(HOLD, 2'b11, 16'h0, 18'h0, 1'b0, 1'b0, F, 18'h0);
    op(C_LD, 2'b01, 16'h0030, 18'h2AA00, 1'b0, 1'b0, F, 18'h0);
    op(HOLD, 2'b11, 16'h0, 18'h0, 1'b0, 1'b1, 18'h3FE00, 18'h2AA00);
    op(HOLD, 2'b11, 16'h0, 18'h0, 1'b0, 1'b0, F, 18'h0);
    op(HOLD, 2'b11, 16'h0, 18'h0, 1'b1, 1'b0, F, 18'h0);
    op(P_RD, 2'b11, 16'h0030, 18'h0, 1'b0, 1'b1, F, 18'h2ABFF);
    repeat (2) op(HOLD, 2'b11, 16'h0, 18'h0, 1'b0, 1'b0, F, 18'h0);
  endtask
  task automatic s_burst;
    logic [15:0] k;
    for (k = 16'h1234; k < 16'h1238; k++)
      op(C_LD, 2'b00, k, {2'b00, k}, 1'b0, 1'b0, F, 18'h0);
    op(HOLD, 2'b11, 16'h0, 18'h0, 1'b0, 1'b0, F, 18'h0);
    op(P_RD, 2'b11, 16'h1236, 18'h0, 1'b0, 1'b1, F, 18'h01236);
    op(STEP, 2'b11, 16'hFFFF, 18'h0, 1'b0, 1'b1, F, 18'h01237);
    op(STEP, 2'b11, 16'hFFFF, 18'h0, 1'b0, 1'b1, F, 18'h01234);
    op(STEP, 2'b11, 16'hFFFF, 18'h0, 1'b0, 1'b1, F, 18'h01235);
    op(HOLD, 2'b11, 16'hFFFF, 18'h0, 1'b0, 1'b1, F, 18'h01235);
    op(STEP, 2'b11, 16'hFFFF, 18'h0, 1'b0, 1'b1, F, 18'h01236);
    op(P_RD, 2'b11, 16'h1234, 18'h0, 1'b0, 1'b1, F, 18'h01234);
    op(STEP, 2'b11, 16'hFFFF, 18'h0, 1'b0, 1'b1, F, 18'h01235);
    op(STEP, 2'b11, 16'hFFFF, 18'h0, 1'b0, 1'b1, F, 18'h01236);
    op(STEP, 2'b11, 16'hFFFF, 18'h0, 1'b0, 1'b1, F, 18'h01237);
    op(STEP, 2'b11, 16'hFFFF, 18'h0, 1'b0, 1'b1, F, 18'h01234);
    repeat (2) op(HOLD, 2'b11, 16'h0, 18'h0, 1'b0, 1'b0, F, 18'h0);
  endtask
  task automatic s_deselect;
    op(P_RD, 2'b11, 16'h1234, 18'h0, 1'b0, 1'b0, F, 18'h0);
    op(DESEL, 2'b11, 16'h1235, 18'h0, 1'b0, 1'b1, 18'h0, 18'h0);
    op(PS_OFF, 2'b11, 16'h1236, 18'h0, 1'b0, 1'b1, 18'h0, 18'h0);
    repeat (2) op(HOLD, 2'b11, 16'h0, 18'h0, 1'b0, 1'b0, F, 18'h0);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Watchdog: the scenarios need well under 200 cycles.
  initial
  begin
    repeat (2000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
  // Reset, then the scenarios in turn.
  initial
  begin
    rst_n = 1'b0;
    {ev, em, ed, e1v, e1m, e1d, e2v, e2m, e2d} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    s_forward();
    s_bytes();
    s_burst();
    s_deselect();
    repeat (3) @(posedge clk);
    report_and_stop();
  end
endmodule
`default_nettype wire
